// ### tam_alarm_ch.sv
`timescale 1ns/1ps
`include "tam_params.svh"
module tam_alarm_ch
  import tam_pkg::*;
#(
  parameter int W = 32,
  parameter int DBW = 24
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic enable_i,
  input wire logic latch_i,
  input wire logic clear_i,
  input wire logic signed [W-1:0] reading_i,
  input wire logic signed [W-1:0] low_i,
  input wire logic signed [W-1:0] high_i,
  input wire logic [DBW-1:0] db_i,
  output logic high_o,
  output logic low_o,
  output logic rise_o
);
  typedef struct packed {
    logic high;
    logic low;
    logic rise;
  } tam_ch_state_t;
  tam_ch_state_t state_reg, state_next;
  logic signed [W:0] db_ext;
  logic signed [W:0] rd_ext;
  logic hi_trip, lo_trip, hi_rel, lo_rel;

  always_comb begin
    db_ext = {{(W+1-DBW){1'b0}}, db_i};
    rd_ext = {reading_i[W-1], reading_i};
    hi_trip = reading_i >= high_i;
    lo_trip = reading_i <= low_i;
    hi_rel = rd_ext <= ($signed({high_i[W-1], high_i}) - db_ext);
    lo_rel = rd_ext >= ($signed({low_i[W-1], low_i}) + db_ext);
    state_next = state_reg;
    state_next.rise = 1'b0;
    if (!enable_i) begin
      state_next.high = 1'b0;
      state_next.low = 1'b0;
    end else if (latch_i) begin
      // Set wins over a clear arriving in the same cycle.
      if (clear_i) begin
        state_next.high = 1'b0;
        state_next.low = 1'b0;
      end
      if (hi_trip) begin
        state_next.high = 1'b1;
      end
      if (lo_trip) begin
        state_next.low = 1'b1;
      end
    end else begin
      if (hi_trip) begin
        state_next.high = 1'b1;
      end else if (hi_rel) begin
        state_next.high = 1'b0;
      end
      if (lo_trip) begin
        state_next.low = 1'b1;
      end else if (lo_rel) begin
        state_next.low = 1'b0;
      end
    end
    state_next.rise = (state_next.high & ~state_reg.high) | (state_next.low & ~state_reg.low);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign high_o = state_reg.high;
  assign low_o = state_reg.low;
  assign rise_o = state_reg.rise;
endmodule

// ### tam_params.svh
`ifndef TAM_PARAMS_SVH
`define TAM_PARAMS_SVH
// Register byte offsets on the bus.
`define TAM_OFS_CTRL       8'h00
`define TAM_OFS_STATUS     8'h04
`define TAM_OFS_MON_LO     8'h08
`define TAM_OFS_MON_HI     8'h0C
`define TAM_OFS_MON_CODE   8'h10
`define TAM_OFS_ALM_BASE   8'h20
`define TAM_OFS_ALM_STRIDE 8'h10
// Per-input alarm register word offsets.
`define TAM_AW_CFG         2'd0
`define TAM_AW_LOW         2'd1
`define TAM_AW_HIGH        2'd2
`define TAM_AW_READ        2'd3
// Control field positions.
`define TAM_CTRL_BIPOLAR   0
`define TAM_CTRL_SRC_LSB   1
`define TAM_CTRL_UNITS_LSB 3
`define TAM_CTRL_CLEAR     8
// Alarm config field positions.
`define TAM_CFG_ENABLE     0
`define TAM_CFG_VISIBLE    1
`define TAM_CFG_AUDIBLE    2
`define TAM_CFG_LATCH      3
`define TAM_CFG_DB_LSB     8
// Readings are signed fixed point, 1/10000 of a unit per LSB.
`define TAM_RST_LOW        32'h0000_0000
`define TAM_RST_HIGH       32'h0098_9680
`define TAM_RST_DB         24'h00_2710
`define TAM_RST_CFG_BITS   4'h6
`define TAM_LIMIT_K_MIN    32'h0000_0000
`define TAM_LIMIT_K_MAX    32'h05F5_E0FF
`define TAM_LIMIT_C_MIN    32'hFFD6_5204
`define TAM_LIMIT_C_MAX    32'h05CB_32FB
`define TAM_LIMIT_S_MIN    32'hFFFE_7960
`define TAM_LIMIT_S_MAX    32'h05F5_E0FF
`define TAM_BLINK_HALF     24'h07_A120
`endif

// ### tam_pkg.sv
package tam_pkg;
  typedef enum logic [1:0] {
    TAM_SRC_NONE = 2'h0,
    TAM_SRC_A = 2'h1,
    TAM_SRC_B = 2'h2
  } tam_src_t;
  typedef enum logic [1:0] {
    TAM_U_KELVIN = 2'h0,
    TAM_U_CELSIUS = 2'h1,
    TAM_U_SENSOR = 2'h2
  } tam_units_t;
  typedef enum logic [2:0] {
    TAM_BS_IDLE = 3'b001,
    TAM_BS_ACK = 3'b010,
    TAM_BS_GAP = 3'b100
  } tam_bus_state_t;
endpackage

// ### tam_scaler.sv
`timescale 1ns/1ps
`include "tam_params.svh"
module tam_scaler
  import tam_pkg::*;
#(
  parameter int W = 32,
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic bipolar_i,
  input wire logic valid_i,
  input wire logic signed [W-1:0] reading_i,
  input wire logic signed [W-1:0] lo_i,
  input wire logic signed [W-1:0] hi_i,
  output logic [CW-1:0] code_o
);
  // Code is offset binary over the full range: 0 is -10 V, the mid code is
  // 0 V (the bottom of the unipolar scale) and all ones is +10 V. Bipolar uses the
  // whole span; unipolar maps the scale onto the upper half of it.
  localparam logic [CW-1:0] CODE_MAX = {CW{1'b1}};
  localparam logic [CW-1:0] CODE_MID = {1'b1, {(CW-1){1'b0}}};
  typedef struct packed {
    logic [CW-1:0] code;
  } tam_sc_state_t;
  tam_sc_state_t state_reg, state_next;
  logic signed [W+1:0] num;
  logic signed [W+1:0] den;
  logic [W+CW+1:0] prod;
  logic [W+CW+1:0] quot;
  logic [CW-1:0] span;
  logic [CW-1:0] base;

  // A full-width divide is slow but readings change rarely; the
  // trade keeps the mapping exact to the last code.
  always_comb begin
    num = {{2{reading_i[W-1]}}, reading_i} - {{2{lo_i[W-1]}}, lo_i};
    den = {{2{hi_i[W-1]}}, hi_i} - {{2{lo_i[W-1]}}, lo_i};
    span = bipolar_i ? CODE_MAX : CODE_MAX - CODE_MID;
    base = bipolar_i ? '0 : CODE_MID;
    prod = '0;
    quot = '0;
    state_next = state_reg;
    if (valid_i) begin
      if (num <= 0 || den <= 0) begin
        state_next.code = base;
      end else if (num >= den) begin
        state_next.code = CODE_MAX;
      end else begin
        prod = (W+CW+2)'(num) * (W+CW+2)'(span);
        quot = prod / (W+CW+2)'(den);
        state_next.code = base + quot[CW-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign code_o = state_reg.code;
endmodule

// ### tam_src_model.sv
`timescale 1ns/1ps
module tam_src_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] live_i,
  input wire logic [63:0] kelvin_i,
  output logic [1:0] valid_o,
  output logic [63:0] kelvin_o,
  output logic [63:0] celsius_o,
  output logic [63:0] sensor_o
);
  // ==========================================================================
  // Acquisition
  // A channel that is not live shows inverted data every cycle, so stale use is caught.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= '0;
      kelvin_o <= '0;
      celsius_o <= '0;
      sensor_o <= '0;
    end else begin
      valid_o <= live_i;
      for (int i = 0; i < 2; i++) begin
        kelvin_o[i*32+:32] <= live_i[i] ? kelvin_i[i*32+:32] : ~kelvin_o[i*32+:32];
        celsius_o[i*32+:32] <= live_i[i] ? kelvin_i[i*32+:32] - 32'h0029_ADEC : ~celsius_o[i*32+:32];
        sensor_o[i*32+:32] <= live_i[i] ? kelvin_i[i*32+:32] >> 1 : ~sensor_o[i*32+:32];
      end
    end
  end
endmodule

// ### tam_top.sv
`timescale 1ns/1ps
`include "tam_params.svh"
module tam_top
  import tam_pkg::*;
#(
  parameter int N_IN = 2,
  parameter int W = 32,
  parameter int CW = 16,
  parameter int DBW = 24,
  parameter logic [23:0] BLINK_HALF = `TAM_BLINK_HALF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [N_IN-1:0] rd_valid_i,
  input wire logic [N_IN*W-1:0] rd_kelvin_i,
  input wire logic [N_IN*W-1:0] rd_celsius_i,
  input wire logic [N_IN*W-1:0] rd_sensor_i,
  input wire logic [N_IN-1:0] pref_units_i,
  input wire logic [N_IN-1:0] alarm_reset_i,
  input wire logic [N_IN-1:0] displayed_i,
  output logic [CW-1:0] mon_code_o,
  output logic led_on_o,
  output logic beep_o,
  output logic [N_IN-1:0] show_alarm_msg_o
);
  // pref_units_i per input: 0 kelvin, 1 sensor units; the low/high setpoints
  // and the reading the alarm compares are both in that unit.
  // alarm_reset_i is the front-panel reset request, one pulse.

  typedef struct packed {
    logic bipolar;
    logic [1:0] src;
    logic [1:0] units;
    logic [W-1:0] mon_lo;
    logic [W-1:0] mon_hi;
    logic [N_IN-1:0] en;
    logic [N_IN-1:0] vis;
    logic [N_IN-1:0] aud;
    logic [N_IN-1:0] latch;
    logic [N_IN*DBW-1:0] db;
    logic [N_IN*W-1:0] low;
    logic [N_IN*W-1:0] high;
    logic clear;
    logic [23:0] blink_cnt;
    logic blink;
    logic beep;
    logic ack;
    logic [31:0] dat;
    tam_bus_state_t bs;
  } tam_state_t;
  tam_state_t state_reg, state_next;

  logic [N_IN-1:0] alm_hi, alm_lo, alm_rise;
  logic [N_IN*W-1:0] rd_alarm;
  logic signed [W-1:0] mon_rd;
  logic mon_valid;
  logic any_vis_en, any_vis_active, any_aud_rise;

  // ==========================================================
  // Unit limits and field access.
  // ==========================================================
  function automatic logic [W-1:0] clamp_units(input logic [1:0] u, input logic [31:0] v);
    logic signed [31:0] lo;
    logic signed [31:0] hi;
    logic signed [31:0] s;
    s = $signed(v);
    case (u)
      2'h1: begin
        lo = $signed(`TAM_LIMIT_C_MIN);
        hi = $signed(`TAM_LIMIT_C_MAX);
      end
      2'h2: begin
        lo = $signed(`TAM_LIMIT_S_MIN);
        hi = $signed(`TAM_LIMIT_S_MAX);
      end
      default: begin
        lo = $signed(`TAM_LIMIT_K_MIN);
        hi = $signed(`TAM_LIMIT_K_MAX);
      end
    endcase
    if (s < lo) begin
      s = lo;
    end else if (s > hi) begin
      s = hi;
    end
    return W'(s);
  endfunction

  function automatic logic [31:0] wmask(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // ==========================================================
  // Per-input alarm channels.
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++) begin : g_ch
      assign rd_alarm[gi*W +: W] = pref_units_i[gi] ? rd_sensor_i[gi*W +: W] : rd_kelvin_i[gi*W +: W];
      tam_alarm_ch #(.W(W), .DBW(DBW)) u_ch (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .enable_i(state_reg.en[gi] & rd_valid_i[gi]),
        .latch_i(state_reg.latch[gi]),
        .clear_i(state_reg.clear | alarm_reset_i[gi]),
        .reading_i($signed(rd_alarm[gi*W +: W])),
        .low_i($signed(state_reg.low[gi*W +: W])),
        .high_i($signed(state_reg.high[gi*W +: W])),
        .db_i(state_reg.db[gi*DBW +: DBW]),
        .high_o(alm_hi[gi]),
        .low_o(alm_lo[gi]),
        .rise_o(alm_rise[gi])
      );
    end
  endgenerate

  // ==========================================================
  // Monitor output source.
  // ==========================================================
  always_comb begin
    mon_rd = '0;
    mon_valid = 1'b0;
    if (state_reg.src == TAM_SRC_A || state_reg.src == TAM_SRC_B) begin
      for (int i = 0; i < N_IN; i++) begin
        if (state_reg.src == 2'(i + 1)) begin
          mon_valid = rd_valid_i[i];
          case (state_reg.units)
            2'h1: mon_rd = $signed(rd_celsius_i[i*W +: W]);
            2'h2: mon_rd = $signed(rd_sensor_i[i*W +: W]);
            default: mon_rd = $signed(rd_kelvin_i[i*W +: W]);
          endcase
        end
      end
    end
  end

  tam_scaler #(.W(W), .CW(CW)) u_scaler (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bipolar_i(state_reg.bipolar),
    .valid_i(mon_valid),
    .reading_i(mon_rd),
    .lo_i($signed(state_reg.mon_lo)),
    .hi_i($signed(state_reg.mon_hi)),
    .code_o(mon_code_o)
  );

  // ==========================================================
  // Annunciators.
  // ==========================================================
  assign any_vis_en = |(state_reg.en & state_reg.vis);
  assign any_vis_active = |(state_reg.en & state_reg.vis & (alm_hi | alm_lo));
  assign any_aud_rise = |(state_reg.en & state_reg.aud & alm_rise);
  // Steady when armed and quiet, blinking while any visible alarm is up.
  assign led_on_o = any_vis_active ? state_reg.blink : any_vis_en;
  assign beep_o = state_reg.beep;
  assign show_alarm_msg_o = displayed_i & state_reg.en & (alm_hi | alm_lo);

  // ==========================================================
  // Register file and Wishbone slave.
  // ==========================================================
  always_comb begin
    logic [7:0] a;
    logic [1:0] idx_w;
    int ch;
    logic [31:0] cfgw;
    a = wb_adr_i;
    idx_w = a[3:2];
    ch = 0;
    cfgw = '0;
    state_next = state_reg;
    state_next.clear = 1'b0;
    state_next.ack = 1'b0;

    if (!any_vis_active || state_reg.blink_cnt == BLINK_HALF) begin
      state_next.blink_cnt = '0;
      state_next.blink = ~state_reg.blink | ~any_vis_active;
    end else begin
      state_next.blink_cnt = state_reg.blink_cnt + 24'd1;
    end
    // Beeper sounds from an audible activation until the alarm is gone.
    if (any_aud_rise) begin
      state_next.beep = 1'b1;
    end else if (!(|(state_reg.en & state_reg.aud & (alm_hi | alm_lo)))) begin
      state_next.beep = 1'b0;
    end

    case (state_reg.bs)
      TAM_BS_IDLE: begin
        if (wb_cyc_i && wb_stb_i) begin
          state_next.ack = 1'b1;
          state_next.bs = TAM_BS_ACK;
          state_next.dat = '0;
          if (a >= `TAM_OFS_ALM_BASE && a < `TAM_OFS_ALM_BASE + 8'(N_IN * 16)) begin
            ch = int'((a - `TAM_OFS_ALM_BASE) >> 4);
            cfgw = {8'h00, state_reg.db[ch*DBW +: DBW]} & 32'hFFFF_FF00;
            cfgw[`TAM_CFG_ENABLE] = state_reg.en[ch];
            cfgw[`TAM_CFG_VISIBLE] = state_reg.vis[ch];
            cfgw[`TAM_CFG_AUDIBLE] = state_reg.aud[ch];
            cfgw[`TAM_CFG_LATCH] = state_reg.latch[ch];
            cfgw[`TAM_CFG_DB_LSB +: DBW] = state_reg.db[ch*DBW +: DBW];
            case (idx_w)
              `TAM_AW_CFG: begin
                state_next.dat = {cfgw[31:6], alm_lo[ch], alm_hi[ch], cfgw[3:0]};
                if (wb_we_i) begin
                  cfgw = wmask(cfgw, wb_dat_i, wb_sel_i);
                  state_next.en[ch] = cfgw[`TAM_CFG_ENABLE];
                  state_next.vis[ch] = cfgw[`TAM_CFG_VISIBLE];
                  state_next.aud[ch] = cfgw[`TAM_CFG_AUDIBLE];
                  state_next.latch[ch] = cfgw[`TAM_CFG_LATCH];
                  state_next.db[ch*DBW +: DBW] = cfgw[`TAM_CFG_DB_LSB +: DBW];
                end
              end
              `TAM_AW_LOW: begin
                state_next.dat = state_reg.low[ch*W +: W];
                if (wb_we_i) begin
                  state_next.low[ch*W +: W] = clamp_units(pref_units_i[ch] ? 2'h2 : 2'h0,
                    wmask(state_reg.low[ch*W +: W], wb_dat_i, wb_sel_i));
                end
              end
              `TAM_AW_HIGH: begin
                state_next.dat = state_reg.high[ch*W +: W];
                if (wb_we_i) begin
                  state_next.high[ch*W +: W] = clamp_units(pref_units_i[ch] ? 2'h2 : 2'h0,
                    wmask(state_reg.high[ch*W +: W], wb_dat_i, wb_sel_i));
                end
              end
              default: begin
                state_next.dat = rd_alarm[ch*W +: W];
              end
            endcase
          end else begin
            case (a)
              `TAM_OFS_CTRL: begin
                state_next.dat = {27'h000_0000, state_reg.units, state_reg.src, state_reg.bipolar};
                if (wb_we_i && wb_sel_i[0]) begin
                  state_next.bipolar = wb_dat_i[`TAM_CTRL_BIPOLAR];
                  state_next.src = wb_dat_i[`TAM_CTRL_SRC_LSB +: 2];
                  state_next.units = wb_dat_i[`TAM_CTRL_UNITS_LSB +: 2];
                end
                if (wb_we_i && wb_sel_i[1]) begin
                  state_next.clear = wb_dat_i[`TAM_CTRL_CLEAR];
                end
              end
              `TAM_OFS_STATUS: begin
                state_next.dat = {28'h000_0000, led_on_o, state_reg.beep, |alm_lo, |alm_hi};
              end
              `TAM_OFS_MON_LO: begin
                state_next.dat = state_reg.mon_lo;
                if (wb_we_i) begin
                  state_next.mon_lo = clamp_units(state_reg.units,
                    wmask(state_reg.mon_lo, wb_dat_i, wb_sel_i));
                end
              end
              `TAM_OFS_MON_HI: begin
                state_next.dat = state_reg.mon_hi;
                if (wb_we_i) begin
                  state_next.mon_hi = clamp_units(state_reg.units,
                    wmask(state_reg.mon_hi, wb_dat_i, wb_sel_i));
                end
              end
              `TAM_OFS_MON_CODE: begin
                state_next.dat = {{(32-CW){1'b0}}, mon_code_o};
              end
              default: begin
                state_next.dat = '0;
              end
            endcase
          end
        end
      end
      TAM_BS_ACK: begin
        state_next.bs = TAM_BS_GAP;
      end
      TAM_BS_GAP: begin
        if (!(wb_cyc_i && wb_stb_i)) begin
          state_next.bs = TAM_BS_IDLE;
        end
      end
      default: begin
        state_next.bs = TAM_BS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= '0;
      state_reg.units <= TAM_U_KELVIN;
      state_reg.mon_lo <= `TAM_RST_LOW;
      state_reg.mon_hi <= `TAM_RST_HIGH;
      state_reg.vis <= '1;
      state_reg.aud <= '1;
      state_reg.db <= {N_IN{`TAM_RST_DB}};
      state_reg.low <= {N_IN{`TAM_RST_LOW}};
      state_reg.high <= {N_IN{`TAM_RST_HIGH}};
      state_reg.bs <= TAM_BS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign wb_ack_o = state_reg.ack;
  assign wb_dat_o = state_reg.dat;
endmodule

// ### tam_top_asserts.sv
`timescale 1ns/1ps
module tam_top_asserts #(
  parameter int N_IN = 2,
  parameter int W = 32,
  parameter int CW = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [N_IN-1:0] rd_valid_i,
  input wire logic [N_IN*W-1:0] rd_kelvin_i,
  input wire logic [N_IN*W-1:0] rd_celsius_i,
  input wire logic [N_IN*W-1:0] rd_sensor_i,
  input wire logic [N_IN-1:0] pref_units_i,
  input wire logic [N_IN-1:0] alarm_reset_i,
  input wire logic [N_IN-1:0] displayed_i,
  input wire logic [CW-1:0] mon_code_o,
  input wire logic led_on_o,
  input wire logic beep_o,
  input wire logic [N_IN-1:0] show_alarm_msg_o
);
  // ==========================================================================
  // Bus handshake
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_resp;
    $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("request not answered next cycle");
  property p_unmapped_zero;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'hFC |-> wb_dat_o == 32'h0000_0000;
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
  // ==========================================================================
  // Outputs
  property p_reset_quiet;
    $fell(rst_i) |-> mon_code_o == '0 && !led_on_o && !beep_o && show_alarm_msg_o == '0;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active after reset");
  property p_msg_displayed;
    (show_alarm_msg_o & ~displayed_i) == '0;
  endproperty
  a_msg_displayed: assert property (p_msg_displayed) else $error("message for hidden input");
  property p_mon_hold;
    rd_valid_i == '0 |=> $stable(mon_code_o);
  endproperty
  a_mon_hold: assert property (p_mon_hold) else $error("monitor moved without reading");
  property p_beep_cause;
    (&$past(displayed_i)) && $past(show_alarm_msg_o) == '0 |-> !beep_o;
  endproperty
  a_beep_cause: assert property (p_beep_cause) else $error("beep without active alarm");
  property p_mon_read;
    wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'h10 |-> wb_dat_o[CW-1:0] == $past(mon_code_o);
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("code register differs from output");
endmodule
bind tam_top tam_top_asserts #(.N_IN(N_IN), .W(W), .CW(CW)) i_chk (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rd_valid_i(rd_valid_i),
  .rd_kelvin_i(rd_kelvin_i), .rd_celsius_i(rd_celsius_i), .rd_sensor_i(rd_sensor_i),
  .pref_units_i(pref_units_i), .alarm_reset_i(alarm_reset_i), .displayed_i(displayed_i),
  .mon_code_o(mon_code_o), .led_on_o(led_on_o), .beep_o(beep_o), .show_alarm_msg_o(show_alarm_msg_o));

// ### tam_top_tb_top.sv
`timescale 1ns/1ps
module tam_top_tb_top;
  import tam_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, led, beep;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0000_0000, rdata;
  logic [1:0] live = 2'h0, areset = 2'h0, shown = 2'h3, pref = 2'h0, valid, msg;
  logic [63:0] kel = '0, rk, rc, rs;
  logic [15:0] code;
  logic [63:0] expq [$];
  logic [7:0] ra [8] = '{8'h00, 8'h08, 8'h0C, 8'h20, 8'h24, 8'h28, 8'h30, 8'h38};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0098_9680, 32'h0027_1006, 32'h0, 32'h0098_9680,
    32'h0027_1006, 32'h0098_9680};
  int failures = 0, tests_run = 0, seed = 21574;
  always #50 clk_i = ~clk_i;
  tam_src_model i_src (.clk_i(clk_i), .rst_i(rst_i), .live_i(live), .kelvin_i(kel), .valid_o(valid),
    .kelvin_o(rk), .celsius_o(rc), .sensor_o(rs));
  tam_top #(.BLINK_HALF(24'h00_0004)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdata), .wb_ack_o(ack),
    .rd_valid_i(valid), .rd_kelvin_i(rk), .rd_celsius_i(rc), .rd_sensor_i(rs), .pref_units_i(pref),
    .alarm_reset_i(areset), .displayed_i(shown), .mon_code_o(code), .led_on_o(led), .beep_o(beep),
    .show_alarm_msg_o(msg));
  // ==========================================================================
  // Tasks
  task report_and_stop;
    $display("Comparisons %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task chk_code(input logic [15:0] e);
    chk({31'h0000_0000, code >= e - 16'h0001 && code <= e + 16'h0001}, 32'h0000_0001);
  endtask
  // For a read, d is the expected word and m the mask of bits that matter.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= w ? d : 32'h0000_0000;
    sel <= 4'hF;
    if (!w) expq.push_back({m, d & m});
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 20) begin
      failures++;
      $display("Error at %0t: no bus answer", $time);
      report_and_stop();
    end
  endtask
  task setk(input logic [31:0] k);
    @(posedge clk_i);
    kel <= {$random(seed), k};
    live <= 2'h3;
    repeat (4) @(posedge clk_i);
  endtask
  task led_ones(output int n);
    n = 0;
    repeat (16) begin
      @(posedge clk_i);
      n += led;
    end
  endtask
  always @(posedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) begin
        failures++;
        $display("Error at %0t: unexpected read answer", $time);
      end else begin
        chk(rdata & expq[0][63:32], expq[0][31:0]);
        void'(expq.pop_front());
      end
    end
  end
  // ==========================================================================
  // Main sequence
  initial begin
    int ones;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) bus(1'b0, ra[i], rv[i], '1);
    bus(1'b1, 8'hFC, $random(seed), '0);
    bus(1'b0, 8'hFC, 32'h0000_0000, '1);
    chk({16'h0000, code}, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0002, '0);
    setk(32'h0000_0000);
    chk({16'h0000, code}, 32'h0000_8000);
    setk(32'h0098_9680);
    chk({16'h0000, code}, 32'h0000_FFFF);
    bus(1'b0, 8'h10, 32'h0000_FFFF, 32'h0000_FFFF);
    setk(32'h0131_2D00);
    chk({16'h0000, code}, 32'h0000_FFFF);
    setk(32'h004C_4B40);
    chk_code(16'hBFFF);
    bus(1'b1, 8'h00, 32'h0000_0000, '0);
    setk(32'h0000_0000);
    chk_code(16'hBFFF);
    bus(1'b1, 8'h00, 32'h0000_0003, '0);
    setk(32'h0000_0000);
    chk({16'h0000, code}, 32'h0000_0000);
    setk(32'h004C_4B40);
    chk_code(16'h7FFF);
    bus(1'b1, 8'h00, 32'h0000_000A, '0);
    setk(32'h0029_ADEC);
    chk({16'h0000, code}, 32'h0000_8000);
    setk(32'h00C2_446C);
    chk({16'h0000, code}, 32'h0000_FFFF);
    bus(1'b1, 8'h00, 32'h0000_0012, '0);
    setk(32'h0098_9680);
    chk_code(16'hBFFF);
    bus(1'b1, 8'h00, 32'h0000_0002, '0);
    bus(1'b1, 8'h08, 32'hFFFF_FFFF, '0);
    bus(1'b0, 8'h08, 32'h0000_0000, '1);
    bus(1'b1, 8'h0C, 32'h7FFF_FFFF, '0);
    bus(1'b0, 8'h0C, 32'h05F5_E0FF, '1);
    bus(1'b1, 8'h24, 32'hFFFF_FFFF, '0);
    bus(1'b0, 8'h24, 32'h0000_0000, '1);
    bus(1'b1, 8'h24, 32'h0007_A120, '0);
    bus(1'b1, 8'h28, 32'h000F_4240, '0);
    // The reading must sit between the setpoints before the alarm is armed.
    setk(32'h000F_1B30);
    bus(1'b1, 8'h20, 32'h00C3_5007, '0);
    led_ones(ones);
    chk(ones, 16);
    chk({30'h0000_0000, msg}, 32'h0000_0000);
    setk(32'h000F_4240);
    chk({30'h0000_0000, msg}, 32'h0000_0001);
    chk({31'h0000_0000, beep}, 32'h0000_0001);
    led_ones(ones);
    chk({31'h0000_0000, ones > 0 && ones < 16}, 32'h0000_0001);
    bus(1'b0, 8'h04, 32'h0000_0001, 32'h0000_0003);
    setk(32'h000E_A600);
    chk({30'h0000_0000, msg}, 32'h0000_0001);
    setk(32'h000E_7EF0);
    chk({30'h0000_0000, msg}, 32'h0000_0000);
    setk(32'h0007_A120);
    chk({30'h0000_0000, msg}, 32'h0000_0001);
    bus(1'b0, 8'h04, 32'h0000_0002, 32'h0000_0003);
    setk(32'h0008_3D60);
    chk({30'h0000_0000, msg}, 32'h0000_0001);
    setk(32'h0008_6470);
    chk({30'h0000_0000, msg}, 32'h0000_0000);
    bus(1'b1, 8'h20, 32'h00C3_500F, '0);
    setk(32'h000F_4240);
    setk(32'h000A_AE60);
    chk({30'h0000_0000, msg}, 32'h0000_0001);
    areset <= 2'h1;
    @(posedge clk_i);
    areset <= 2'h0;
    repeat (4) @(posedge clk_i);
    chk({30'h0000_0000, msg}, 32'h0000_0000);
    setk(32'h000F_4240);
    setk(32'h000A_AE60);
    bus(1'b1, 8'h00, 32'h0000_0102, '0);
    repeat (4) @(posedge clk_i);
    chk({30'h0000_0000, msg}, 32'h0000_0000);
    chk({31'h0000_0000, beep}, 32'h0000_0000);
    // In sensor units a small negative setpoint is legal and must be kept.
    pref <= 2'h1;
    bus(1'b1, 8'h24, 32'hFFFF_FFFF, '0);
    bus(1'b0, 8'h24, 32'hFFFF_FFFF, '1);
    report_and_stop();
  end
endmodule
